// ### pds_pkg.sv
package pds_pkg;

  // channel count and field widths
  localparam int NUM_CH   = 10;
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 8;
  localparam int PERIOD_W = 13;
  localparam int ONT_W    = 16;
  localparam int CUR_W    = 6;
  localparam int CNT_W    = 17;
  localparam int SLOT_W   = CNT_W + 4;
  localparam int IDX_W    = 4;

  // register byte offsets
  localparam logic [ADDR_W-1:0] ADDR_EN_A      = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_EN_B      = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_PER_LO    = 8'h06;
  localparam logic [ADDR_W-1:0] ADDR_PER_HI    = 8'h07;
  localparam logic [ADDR_W-1:0] ADDR_GRP_A     = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_GRP_B     = 8'h09;
  localparam logic [ADDR_W-1:0] ADDR_ONT_FIRST = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_ONT_LAST  = 8'h23;
  localparam logic [ADDR_W-1:0] ADDR_CUR_FIRST = 8'h24;
  localparam logic [ADDR_W-1:0] ADDR_CUR_LAST  = 8'h2d;
  localparam logic [ADDR_W-1:0] ADDR_STAT_A    = 8'h30;
  localparam logic [ADDR_W-1:0] ADDR_STAT_B    = 8'h31;

  // field positions inside the split registers
  localparam int EN_B_LSB  = 8;
  localparam int EN_B_W    = 2;
  localparam int PER_HI_W  = PERIOD_W - 8;

  // reset values
  localparam logic [NUM_CH-1:0]   EN_RST     = 10'h000;
  localparam logic [NUM_CH-1:0]   GRP_RST    = 10'h000;
  localparam logic [PERIOD_W-1:0] PERIOD_RST = 13'h0000;
  localparam logic [ONT_W-1:0]    ONT_RST    = 16'h0000;
  localparam logic [CUR_W-1:0]    CUR_RST    = 6'h00;

  // timing, all in picoseconds
  localparam int CLOCK_PS       = 100000;
  localparam int PERIOD_STEP_PS = 1500000;
  localparam int ON_STEP_PS     = 150000;
  localparam int MIN_ON_PS      = 1000000;
  localparam int RATIO_GCD_PS   = 50000;

  // derived cycle counts and the on-time step ratio
  localparam int PERIOD_STEP_CYC = PERIOD_STEP_PS / CLOCK_PS;
  localparam int MIN_ON_CYC      = (MIN_ON_PS + CLOCK_PS - 1) / CLOCK_PS;
  localparam int ON_STEP_NUM     = ON_STEP_PS / RATIO_GCD_PS;
  localparam int ON_STEP_DEN     = CLOCK_PS / RATIO_GCD_PS;

  // register access request from the serial front end
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } pds_reg_req_t;

  // per-channel schedule for one dimming period
  typedef struct packed {
    logic             en;
    logic [CNT_W-1:0] start;
    logic [CNT_W-1:0] on_cyc;
  } pds_sched_t;

  typedef enum logic {
    CH_IDLE,
    CH_ON
  } pds_ch_state_t;

endpackage : pds_pkg

// ### pds_scheduler.sv
`timescale 1ns/100ps
module pds_scheduler
  import pds_pkg::*;
(
  // clock, reset, enable
  input  wire logic                      i_clock,
  input  wire logic                      i_sys_rst,
  input  wire logic                      i_clk_en,
  // register access from the serial front end
  input  wire pds_reg_req_t              i_reg_req,
  output logic      [DATA_W-1:0]         o_reg_rdata,
  output logic                           o_reg_rvalid,
  // current sink controls
  output logic      [NUM_CH-1:0]         o_sink_channel_pin,
  output logic      [NUM_CH-1:0][CUR_W-1:0] o_sink_current
);

  // after reset every setting is zero: all channels off, no groups,
  // a period of fifteen cycles and the shortest on-time
  // live registers written by the host
  logic [NUM_CH-1:0]   en_ff;
  logic [NUM_CH-1:0]   grp_ff;
  logic [PERIOD_W-1:0] per_ff;
  logic [ONT_W-1:0]    ont_ff    [NUM_CH];
  logic [CUR_W-1:0]    cur_ff    [NUM_CH];
  // shadows used by the running period
  logic [NUM_CH-1:0]   en_sh_ff;
  logic [NUM_CH-1:0]   grp_sh_ff;
  logic [ONT_W-1:0]    ont_sh_ff [NUM_CH];
  logic [CNT_W-1:0]    per_cyc_sh_ff;
  // read port
  logic [DATA_W-1:0]   rdata_ff;
  logic                rvalid_ff;
  logic [DATA_W-1:0]   nxt_rdata;
  // timebase
  logic [CNT_W-1:0]    count;
  logic [CNT_W-1:0]    period_cyc;
  logic                period_start;
  // schedule
  logic [CNT_W-1:0]    slot_start [NUM_CH];
  logic [CNT_W-1:0]    on_cyc     [NUM_CH];
  logic [IDX_W-1:0]    lead_idx   [NUM_CH];
  pds_sched_t          sched      [NUM_CH];
  logic [NUM_CH-1:0]   gate;

  // shared by the write strobes and the read selects
  // one-hot address match against base plus offset
  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                    input logic [ADDR_W-1:0] base,
                                    input int                ofs);
    addr_hit = (addr == base + ADDR_W'(ofs));
  endfunction : addr_hit

  // group bit k ties channel k to channel k-1; bit 0 has no lower
  // neighbour, so it is stored and read back but never followed;
  // a chain of set bits leads down to the lowest member of the group
  // walk down while a channel is tied to its lower neighbour
  function automatic logic [IDX_W-1:0] lead_of(input logic [NUM_CH-1:0] grp,
                                               input int                k);
    int j;
    j = k;
    for (int i = NUM_CH - 1; i > 0; i--) begin
      if ((i == j) && grp[i]) begin
        j = i - 1;
      end
    end
    lead_of = IDX_W'(j);
  endfunction : lead_of

  // a 0.15 us step is one and a half cycles, so odd step counts round
  // up to the next cycle and a pulse is never shorter than programmed
  // on-time steps to cycles, rounded up, floored at the minimum pulse
  function automatic logic [CNT_W-1:0] on_cycles(input logic [ONT_W-1:0] ont);
    logic [ONT_W+1:0] prod;
    logic [ONT_W+1:0] quo;
    prod = ({2'b00, ont} * (ONT_W+2)'(ON_STEP_NUM)) + (ONT_W+2)'(ON_STEP_DEN - 1);
    quo  = prod / (ONT_W+2)'(ON_STEP_DEN);
    if (quo < (ONT_W+2)'(MIN_ON_CYC)) begin
      quo = (ONT_W+2)'(MIN_ON_CYC);
    end
    on_cycles = CNT_W'(quo);
  endfunction : on_cycles

  // register map, one byte per address:
  //   enables and group bits split into a low byte and two high bits
  //   period n as a low byte and five high bits
  //   on-time pairs with the low byte on the even address
  //   six-bit current per channel; gate status is read only
  // a half-written on-time is used if a period starts between its bytes,
  // so the host should rewrite it while the channel is off
  // write decode for the scalar registers
  logic wr_en_a;
  logic wr_en_b;
  logic wr_per_lo;
  logic wr_per_hi;
  logic wr_grp_a;
  logic wr_grp_b;
  assign wr_en_a   = i_reg_req.wr && addr_hit(i_reg_req.addr, ADDR_EN_A, 0);
  assign wr_en_b   = i_reg_req.wr && addr_hit(i_reg_req.addr, ADDR_EN_B, 0);
  assign wr_per_lo = i_reg_req.wr && addr_hit(i_reg_req.addr, ADDR_PER_LO, 0);
  assign wr_per_hi = i_reg_req.wr && addr_hit(i_reg_req.addr, ADDR_PER_HI, 0);
  assign wr_grp_a  = i_reg_req.wr && addr_hit(i_reg_req.addr, ADDR_GRP_A, 0);
  assign wr_grp_b  = i_reg_req.wr && addr_hit(i_reg_req.addr, ADDR_GRP_B, 0);

  // unused high bits of the split registers are dropped on write
  // scalar registers; the period is taken by the timebase at its wrap
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      en_ff  <= EN_RST;
      grp_ff <= GRP_RST;
      per_ff <= PERIOD_RST;
    end else if (i_clk_en) begin
      if (wr_en_a) en_ff[EN_B_LSB-1:0] <= i_reg_req.wdata;
      if (wr_en_b) en_ff[NUM_CH-1:EN_B_LSB] <= i_reg_req.wdata[EN_B_W-1:0];
      if (wr_grp_a) grp_ff[EN_B_LSB-1:0] <= i_reg_req.wdata;
      if (wr_grp_b) grp_ff[NUM_CH-1:EN_B_LSB] <= i_reg_req.wdata[EN_B_W-1:0];
      if (wr_per_lo) per_ff[7:0] <= i_reg_req.wdata;
      if (wr_per_hi) per_ff[PERIOD_W-1:8] <= i_reg_req.wdata[PER_HI_W-1:0];
    end
  end

  // a cleared enable thus never cuts a pulse in the middle of a period
  // enable and group shadows follow the live copy only at a period start
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      en_sh_ff  <= EN_RST;
      grp_sh_ff <= GRP_RST;
    end else if (i_clk_en && period_start) begin
      en_sh_ff  <= en_ff;
      grp_sh_ff <= grp_ff;
    end
  end

  // slot positions must use the period length of the running count;
  // the timebase swaps its length one cycle before the delayed count
  // wraps, so a live length could place a start on a stale count value
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      per_cyc_sh_ff <= CNT_W'(PERIOD_STEP_CYC);
    end else if (i_clk_en && period_start) begin
      per_cyc_sh_ff <= period_cyc;
    end
  end

  // each channel gets its own write decode, slot, on-time and gate;
  // the gate module only sees a start point, a length and an enable,
  // so grouping is settled here and the gate never knows about it
  // per-channel registers, schedule and gates
  genvar k;
  generate
    for (k = 0; k < NUM_CH; k++) begin : g_ch
      logic wr_ont_lo;
      logic wr_ont_hi;
      logic wr_cur;
      logic [SLOT_W-1:0] slot_prod;

      // little-endian byte pair per on-time
      assign wr_ont_lo = i_reg_req.wr && addr_hit(i_reg_req.addr, ADDR_ONT_FIRST, 2 * k);
      assign wr_ont_hi = i_reg_req.wr && addr_hit(i_reg_req.addr, ADDR_ONT_FIRST, 2 * k + 1);
      assign wr_cur    = i_reg_req.wr && addr_hit(i_reg_req.addr, ADDR_CUR_FIRST, k);

      always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
          ont_ff[k]    <= ONT_RST;
          ont_sh_ff[k] <= ONT_RST;
          cur_ff[k]    <= CUR_RST;
        end else if (i_clk_en) begin
          if (wr_ont_lo) ont_ff[k][7:0] <= i_reg_req.wdata;
          if (wr_ont_hi) ont_ff[k][15:8] <= i_reg_req.wdata;
          if (wr_cur) cur_ff[k] <= i_reg_req.wdata[CUR_W-1:0];
          if (period_start) ont_sh_ff[k] <= ont_ff[k];
        end
      end

      // slot k sits k tenths into the period; empty slots keep their place
      assign slot_prod     = SLOT_W'(k) * {4'h0, per_cyc_sh_ff};
      assign slot_start[k] = CNT_W'(slot_prod / SLOT_W'(NUM_CH));
      assign on_cyc[k]     = on_cycles(ont_sh_ff[k]);

      // members borrow the leader's slot and on-time
      assign lead_idx[k]     = lead_of(grp_sh_ff, k);
      assign sched[k].start  = slot_start[lead_idx[k]];
      assign sched[k].on_cyc = on_cyc[lead_idx[k]];
      assign sched[k].en     = en_sh_ff[k] && en_sh_ff[lead_idx[k]];

      pds_sink_gate u_gate (
        .i_clock   (i_clock),
        .i_sys_rst (i_sys_rst),
        .i_clk_en  (i_clk_en),
        .i_count   (count),
        .i_sched   (sched[k]),
        .o_gate    (gate[k])
      );

      // current setting is never touched by grouping
      assign o_sink_current[k] = cur_ff[k];
    end
  endgenerate

  // timing alignment:
  //   the timebase wraps its count and raises the start pulse in the same cycle
  //   the shadows latch on that pulse and take effect as the delayed count steps to zero
  //   every gate thus compares settings and count of the same period
  //   a rewritten period length waits for the wrap, so none is cut short
  pds_timebase u_timebase (
    .i_clock        (i_clock),
    .i_sys_rst      (i_sys_rst),
    .i_clk_en       (i_clk_en),
    .i_period_n     (per_ff),
    .o_count        (count),
    .o_period_cyc   (period_cyc),
    .o_period_start (period_start)
  );

  // read index for the paired and the single-byte arrays
  logic [IDX_W-1:0] rd_ont_idx;
  logic [IDX_W-1:0] rd_cur_idx;
  logic             rd_in_ont;
  logic             rd_in_cur;
  assign rd_in_ont  = (i_reg_req.addr >= ADDR_ONT_FIRST) && (i_reg_req.addr <= ADDR_ONT_LAST);
  assign rd_in_cur  = (i_reg_req.addr >= ADDR_CUR_FIRST) && (i_reg_req.addr <= ADDR_CUR_LAST);
  assign rd_ont_idx = IDX_W'((i_reg_req.addr - ADDR_ONT_FIRST) >> 1);
  assign rd_cur_idx = IDX_W'(i_reg_req.addr - ADDR_CUR_FIRST);

  // named selects for the single-byte registers
  logic sel_en_a;
  logic sel_en_b;
  logic sel_per_lo;
  logic sel_per_hi;
  logic sel_grp_a;
  logic sel_grp_b;
  logic sel_stat_a;
  logic sel_stat_b;
  assign sel_en_a   = addr_hit(i_reg_req.addr, ADDR_EN_A, 0);
  assign sel_en_b   = addr_hit(i_reg_req.addr, ADDR_EN_B, 0);
  assign sel_per_lo = addr_hit(i_reg_req.addr, ADDR_PER_LO, 0);
  assign sel_per_hi = addr_hit(i_reg_req.addr, ADDR_PER_HI, 0);
  assign sel_grp_a  = addr_hit(i_reg_req.addr, ADDR_GRP_A, 0);
  assign sel_grp_b  = addr_hit(i_reg_req.addr, ADDR_GRP_B, 0);
  assign sel_stat_a = addr_hit(i_reg_req.addr, ADDR_STAT_A, 0);
  assign sel_stat_b = addr_hit(i_reg_req.addr, ADDR_STAT_B, 0);

  // read mux; unmapped addresses and unused bits read zero
  always_comb begin
    nxt_rdata = '0;
    if (sel_en_a) begin
      nxt_rdata = en_ff[EN_B_LSB-1:0];
    end else if (sel_en_b) begin
      nxt_rdata = {6'h00, en_ff[NUM_CH-1:EN_B_LSB]};
    end else if (sel_per_lo) begin
      nxt_rdata = per_ff[7:0];
    end else if (sel_per_hi) begin
      nxt_rdata = {3'h0, per_ff[PERIOD_W-1:8]};
    end else if (sel_grp_a) begin
      nxt_rdata = grp_ff[EN_B_LSB-1:0];
    end else if (sel_grp_b) begin
      nxt_rdata = {6'h00, grp_ff[NUM_CH-1:EN_B_LSB]};
    end else if (rd_in_ont) begin
      nxt_rdata = i_reg_req.addr[0] ? ont_ff[rd_ont_idx][15:8] : ont_ff[rd_ont_idx][7:0];
    end else if (rd_in_cur) begin
      nxt_rdata = {2'h0, cur_ff[rd_cur_idx]};
    end else if (sel_stat_a) begin
      nxt_rdata = gate[EN_B_LSB-1:0];
    end else if (sel_stat_b) begin
      nxt_rdata = {6'h00, gate[NUM_CH-1:EN_B_LSB]};
    end
  end

  // the answer comes one cycle after the strobe; a read and a write to
  // one address in the same cycle return the value before the write
  // read data is held until the next read
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      rdata_ff  <= '0;
      rvalid_ff <= 1'b0;
    end else if (i_clk_en) begin
      rvalid_ff <= i_reg_req.rd;
      if (i_reg_req.rd) rdata_ff <= nxt_rdata;
    end
  end

  // every output comes straight from a flip-flop here or in a gate
  assign o_reg_rdata        = rdata_ff;
  assign o_reg_rvalid       = rvalid_ff;
  assign o_sink_channel_pin = gate;

endmodule : pds_scheduler

// ### pds_scheduler_assertions.sv
`timescale 1ns/100ps
module pds_scheduler_chk
  import pds_pkg::*;
(
  // clock, reset and register port
  input wire logic                         i_clock,
  input wire logic                         i_sys_rst,
  input wire logic                         i_clk_en,
  input wire pds_reg_req_t                 i_reg_req,
  input wire logic [DATA_W-1:0]            o_reg_rdata,
  input wire logic                         o_reg_rvalid,
  // current sink controls
  input wire logic [NUM_CH-1:0]            o_sink_channel_pin,
  input wire logic [NUM_CH-1:0][CUR_W-1:0] o_sink_current
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  // accepted accesses
  wire rd_take = i_clk_en && i_reg_req.rd;
  wire wr_take = i_clk_en && i_reg_req.wr;

  // length of the running ch1 pulse; saturates so a long pulse never wraps
  logic [7:0] run_ff;
  logic [7:0] nxt_run;
  assign nxt_run = !o_sink_channel_pin[0] ? 8'h00 : (run_ff == 8'hff) ? run_ff : run_ff + 8'h01;
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) run_ff <= 8'h00;
    else if (i_clk_en) run_ff <= nxt_run;
  end

  property p_rd_answer;
    rd_take |=> o_reg_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered next cycle");
  property p_no_stray;
    i_clk_en && !i_reg_req.rd |=> !o_reg_rvalid;
  endproperty
  a_no_stray: assert property (p_no_stray) else $error("read valid without a read");
  property p_unmapped;
    rd_take && i_reg_req.addr == 8'h50 |=> o_reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  sequence s_wr_then_rd;
    (wr_take && i_reg_req.addr == ADDR_ONT_LAST) ##1 (rd_take && !i_reg_req.wr && i_reg_req.addr == ADDR_ONT_LAST);
  endsequence
  property p_readback;
    s_wr_then_rd |=> o_reg_rdata == $past(i_reg_req.wdata, 2);
  endproperty
  a_readback: assert property (p_readback) else $error("on-time byte read back wrong");
  property p_rdata_hold;
    !o_reg_rvalid && !$past(i_sys_rst) |-> $stable(o_reg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");
  property p_cur_write;
    wr_take && i_reg_req.addr == ADDR_CUR_FIRST |=> o_sink_current[0] == $past(i_reg_req.wdata[CUR_W-1:0]);
  endproperty
  a_cur_write: assert property (p_cur_write) else $error("ch1 current not applied");
  property p_gate_reset;
    disable iff (1'b0) i_sys_rst |=> o_sink_channel_pin == '0;
  endproperty
  a_gate_reset: assert property (p_gate_reset) else $error("gate high after reset");
  property p_min_on;
    $fell(o_sink_channel_pin[0]) |-> run_ff >= 8'd10;
  endproperty
  a_min_on: assert property (p_min_on) else $error("ch1 pulse shorter than minimum");

  // main scenarios reached
  c_pulse: cover property ($rose(o_sink_channel_pin[0]));
  c_readback: cover property (s_wr_then_rd);
  c_pair: cover property (o_sink_channel_pin[1:0] == 2'b11);
endmodule : pds_scheduler_chk

bind pds_scheduler pds_scheduler_chk u_chk (
  .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en), .i_reg_req(i_reg_req),
  .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
  .o_sink_channel_pin(o_sink_channel_pin), .o_sink_current(o_sink_current)
);

// ### pds_sink_gate.sv
`timescale 1ns/100ps
module pds_sink_gate
  import pds_pkg::*;
(
  // clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_sys_rst,
  input  wire logic             i_clk_en,
  // schedule and timebase
  input  wire logic [CNT_W-1:0] i_count,
  input  wire pds_sched_t       i_sched,
  // gate to the current sink
  output logic                  o_gate
);

  pds_ch_state_t    state_ff;
  logic [CNT_W-1:0] remain_ff;
  logic             gate_ff;
  logic             hit;

  assign hit = i_sched.en && (i_count == i_sched.start);

  // pulse runs on past slot boundaries; only its own count or a cleared enable ends it
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      state_ff  <= CH_IDLE;
      remain_ff <= '0;
      gate_ff   <= 1'b0;
    end else if (i_clk_en) begin
      case (state_ff)
        CH_IDLE: begin
          if (hit) begin
            state_ff  <= CH_ON;
            gate_ff   <= 1'b1;
            remain_ff <= i_sched.on_cyc - CNT_W'(1);
          end
        end
        CH_ON: begin
          if (!i_sched.en) begin
            state_ff <= CH_IDLE;
            gate_ff  <= 1'b0;
          end else if (hit) begin
            remain_ff <= i_sched.on_cyc - CNT_W'(1);
          end else if (remain_ff == '0) begin
            state_ff <= CH_IDLE;
            gate_ff  <= 1'b0;
          end else begin
            remain_ff <= remain_ff - CNT_W'(1);
          end
        end
        default: begin
          state_ff <= CH_IDLE;
          gate_ff  <= 1'b0;
        end
      endcase
    end
  end

  assign o_gate = gate_ff;

endmodule : pds_sink_gate

// ### pds_sink_model.sv
`timescale 1ns/100ps
module pds_sink_model
  import pds_pkg::*;
(
  // clock and reset
  input  wire logic              i_clock,
  input  wire logic              i_sys_rst,
  // gates from the scheduler
  input  wire logic [NUM_CH-1:0] i_gate,
  // per channel: last rise tick, last width, rise-to-rise, rise count
  output int                     o_rise  [NUM_CH],
  output int                     o_width [NUM_CH],
  output int                     o_per   [NUM_CH],
  output int                     o_nrise [NUM_CH]
);
  int                tick = 0;
  int                run [NUM_CH];
  logic [NUM_CH-1:0] prev = '0;

  // a sink has no timing of its own, it only logs how its gate moves
  always @(posedge i_clock) begin
    tick <= tick + 1;
    prev <= i_gate;
    for (int k = 0; k < NUM_CH; k++) begin
      if (i_sys_rst) begin
        o_nrise[k] <= 0;
        run[k] <= 0;
      end else if (i_gate[k] && !prev[k]) begin
        o_per[k] <= tick - o_rise[k];
        o_rise[k] <= tick;
        o_nrise[k] <= o_nrise[k] + 1;
        run[k] <= 1;
      end else if (i_gate[k]) begin
        run[k] <= run[k] + 1;
      end else if (prev[k]) begin
        o_width[k] <= run[k];
        run[k] <= 0;
      end
    end
  end
endmodule : pds_sink_model

// ### pds_timebase.sv
`timescale 1ns/100ps
module pds_timebase
  import pds_pkg::*;
(
  // clock and reset
  input  wire logic                i_clock,
  input  wire logic                i_sys_rst,
  input  wire logic                i_clk_en,
  // period setting
  input  wire logic [PERIOD_W-1:0] i_period_n,
  // timebase outputs
  output logic      [CNT_W-1:0]    o_count,
  output logic      [CNT_W-1:0]    o_period_cyc,
  output logic                     o_period_start
);

  logic [CNT_W-1:0] count_ff;
  logic [CNT_W-1:0] count_q_ff;
  logic [CNT_W-1:0] lim_ff;
  logic             start_ff;
  logic [CNT_W-1:0] nxt_lim;
  logic             wrap;

  // period in cycles is (n+1) steps of 1.5 us
  assign nxt_lim = CNT_W'((i_period_n + 14'h0001) * CNT_W'(PERIOD_STEP_CYC));
  assign wrap    = (count_ff == lim_ff - CNT_W'(1));

  // the new period length is taken only at a wrap so no period is cut short
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      count_ff   <= '0;
      count_q_ff <= '0;
      lim_ff     <= CNT_W'(PERIOD_STEP_CYC);
      start_ff   <= 1'b1;
    end else if (i_clk_en) begin
      count_ff   <= wrap ? '0 : count_ff + CNT_W'(1);
      count_q_ff <= count_ff;
      start_ff   <= wrap;
      if (wrap) begin
        lim_ff <= nxt_lim;
      end
    end
  end

  // delayed count lines up with shadows latched on the start pulse
  assign o_count        = count_q_ff;
  assign o_period_cyc   = lim_ff;
  assign o_period_start = start_ff;

endmodule : pds_timebase

// ### tb_polyphase_dimming_scheduler.sv
`timescale 1ns/100ps
module tb_polyphase_dimming_scheduler
  import pds_pkg::*;
;
  logic                         i_clock;
  logic                         i_sys_rst;
  logic                         i_clk_en;
  pds_reg_req_t                 i_reg_req;
  logic [DATA_W-1:0]            o_reg_rdata;
  logic                         o_reg_rvalid;
  logic [NUM_CH-1:0]            o_sink_channel_pin;
  logic [NUM_CH-1:0][CUR_W-1:0] o_sink_current;
  int                           rise  [NUM_CH];
  int                           width [NUM_CH];
  int                           per   [NUM_CH];
  int                           nrise [NUM_CH];
  int                           snap  [NUM_CH];
  int                           fail_count = 0;
  int                           num_checks = 0;
  logic [DATA_W-1:0]            rd;

  pds_scheduler u_dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en),
    .i_reg_req(i_reg_req), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
    .o_sink_channel_pin(o_sink_channel_pin), .o_sink_current(o_sink_current));
  pds_sink_model u_sink (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_gate(o_sink_channel_pin),
    .o_rise(rise), .o_width(width), .o_per(per), .o_nrise(nrise));

  // 100 ns clock
  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one register port cycle, launched just after an edge
  task drive(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_reg_req <= '{wr: w, rd: r, addr: a, wdata: d};
  endtask : drive

  task wreg(input logic [7:0] a, input logic [7:0] d);
    drive(1'b1, 1'b0, a, d);
    drive(1'b0, 1'b0, 8'h00, 8'h00);
  endtask : wreg

  task rreg(input logic [7:0] a, output logic [7:0] d);
    drive(1'b0, 1'b1, a, 8'h00);
    drive(1'b0, 1'b0, 8'h00, 8'h00);
    #1;
    chk(o_reg_rvalid, 1);
    d = o_reg_rdata;
  endtask : rreg

  // waits whole cycles, then lets the edge's updates land
  task wait_cyc(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask : wait_cyc

  // start of channel j against ch1, modulo the 150-cycle period
  task chk_slot(input int j, input int off);
    chk(((rise[j] - rise[0]) % 150 + 150) % 150, off);
  endtask : chk_slot

  task test_regs;
    rreg(ADDR_EN_A, rd);
    chk(rd, 8'h00);
    rreg(8'h50, rd);
    chk(rd, 8'h00);
    wreg(ADDR_EN_B, 8'hff);
    rreg(ADDR_EN_B, rd);
    chk(rd, 8'h03);
    drive(1'b1, 1'b0, ADDR_ONT_LAST, 8'ha5);
    drive(1'b0, 1'b1, ADDR_ONT_LAST, 8'h00);
    drive(1'b0, 1'b0, 8'h00, 8'h00);
    #1;
    chk(o_reg_rdata, 8'ha5);
    wreg(ADDR_ONT_LAST, 8'h00);
    wreg(ADDR_EN_B, 8'h00);
    // a frozen block must not take a read
    @(posedge i_clock);
    i_clk_en <= 1'b0;
    drive(1'b0, 1'b1, ADDR_EN_A, 8'h00);
    drive(1'b0, 1'b0, 8'h00, 8'h00);
    #1;
    chk(o_reg_rvalid, 0);
    @(posedge i_clock);
    i_clk_en <= 1'b1;
    $display("test regs done");
  endtask : test_regs

  task test_slots;
    wreg(ADDR_PER_LO, 8'h09);
    wreg(ADDR_PER_HI, 8'h00);
    wreg(8'h10, 8'h14);
    wreg(8'h12, 8'h07);
    wreg(ADDR_EN_A, 8'hff);
    wreg(ADDR_EN_B, 8'h03);
    wait_cyc(500);
    for (int j = 0; j < NUM_CH; j++) chk_slot(j, 15 * j);
    chk(width[0], 30);
    chk(width[1], 11);
    chk(width[2], 10);
    chk(per[0], 150);
    rreg(ADDR_PER_LO, rd);
    chk(rd, 8'h09);
    $display("test slots done");
  endtask : test_slots

  task test_group;
    automatic int off [NUM_CH] = '{0, 0, 30, 30, 30, 75, 90, 105, 120, 135};
    wreg(ADDR_GRP_A, 8'h1a);
    wreg(8'h16, 8'h28);
    wait_cyc(500);
    for (int j = 0; j < NUM_CH; j++) chk_slot(j, off[j]);
    chk(width[1], 30);
    chk(per[1], 150);
    chk(width[3], 10);
    chk(width[4], 10);
    $display("test group done");
  endtask : test_group

  task test_enable;
    wreg(ADDR_EN_A, 8'hfb);
    wait_cyc(300);
    snap = nrise;
    wait_cyc(300);
    for (int j = 2; j < 5; j++) chk(nrise[j], snap[j]);
    wreg(ADDR_EN_A, 8'hf7);
    wait_cyc(300);
    snap = nrise;
    wait_cyc(300);
    chk(nrise[3], snap[3]);
    chk(nrise[4], snap[4] + 2);
    chk(width[4], 10);
    chk_slot(4, 30);
    $display("test enable done");
  endtask : test_enable

  task test_current;
    for (int k = 0; k < NUM_CH; k++) begin
      wreg(ADDR_CUR_FIRST + 8'(k), 8'(k + 1));
      #1;
      chk(o_sink_current[k], k + 1);
    end
    $display("test current done");
  endtask : test_current

  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  // tests need about 2500 cycles, so 1 ms leaves a wide margin
  initial begin
    #1000000;
    fail_count++;
    $display("ERROR t=%0t watchdog expired", $time);
    end_sim();
  end

  initial begin
    i_sys_rst = 1'b1;
    i_clk_en = 1'b1;
    i_reg_req = '0;
    repeat (5) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    test_regs();
    test_slots();
    test_group();
    test_enable();
    test_current();
    end_sim();
  end
endmodule : tb_polyphase_dimming_scheduler
